// [spi_flash_pkg.sv]
// Purpose: shared constants and types for the serial flash protection block
// Assumes: 40 MHz core clock, serial bits most significant first
// Notes:   self-timed cycle lengths are top-level parameters
package spi_flash_pkg;

    // instruction opcodes
    localparam logic [7:0] OP_LATCH_SET    = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0] OP_IDENT_READ   = 8'h9F;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
    localparam logic [7:0] OP_BULK_ERASE   = 8'hC7;

    // status register bit positions, write mask and reset value
    localparam int BIT_BUSY    = 0;
    localparam int BIT_LATCH   = 1;
    localparam int BIT_PROT_LO = 2;
    localparam int BIT_PROT_HI = 3;
    localparam int BIT_SWD     = 7;
    localparam logic [7:0] STATUS_WRITE_MASK = 8'h8C;
    localparam logic [7:0] NV_RESET          = 8'h00;

    // frame lengths in whole bytes, plus byte and bit positions and identification size
    localparam logic [2:0] BYTES_SHORT        = 3'h1;
    localparam logic [2:0] BYTES_STATUS_WRITE = 3'h2;
    localparam logic [2:0] BYTES_SECTOR_ERASE = 3'h4;
    localparam logic [2:0] BYTES_PROGRAM_MIN  = 3'h5;
    localparam logic [2:0] BYTES_MAX          = 3'h7;
    localparam logic [2:0] BYTE_ADDR_MID      = 3'h2;
    localparam logic [2:0] BIT_LAST           = 3'h7;
    localparam logic [2:0] ID_BYTES           = 3'h3;
    localparam int         ID_BITS            = 24;

    // self-timed cycle lengths
    localparam int CLK_MHZ              = 40;
    localparam int T_STATUS_WRITE_US    = 10;
    localparam int T_PAGE_PROGRAM_US    = 20;
    localparam int T_SECTOR_ERASE_US    = 100;
    localparam int T_BULK_ERASE_US      = 200;
    localparam int STATUS_WRITE_CYCLES  = T_STATUS_WRITE_US * CLK_MHZ;
    localparam int PAGE_PROGRAM_CYCLES  = T_PAGE_PROGRAM_US * CLK_MHZ;
    localparam int SECTOR_ERASE_CYCLES  = T_SECTOR_ERASE_US * CLK_MHZ;
    localparam int BULK_ERASE_CYCLES    = T_BULK_ERASE_US * CLK_MHZ;

    typedef enum {CMD_NONE, CMD_LATCH_SET, CMD_LATCH_CLEAR, CMD_IDENT_READ,
                  CMD_STATUS_READ, CMD_STATUS_WRITE, CMD_PROGRAM, CMD_SECTOR,
                  CMD_BULK} cmd_type;

    typedef enum {CYC_IDLE, CYC_STATUS, CYC_ARRAY} cyc_type;

    typedef struct packed {
        logic selN;
        logic sclk;
        logic dataIn;
        logic writeProtN;
    } pins_type;

    // block-protect setting against sector number
    function automatic logic isProtected(input logic [1:0] prot, input logic [1:0] sector);
        logic hit;
        hit = 1'b0;
        unique case (prot)
            2'h0: hit = 1'b0;
            2'h1: hit = (sector == 2'h3);
            2'h2: hit = sector[1];
            2'h3: hit = 1'b1;
        endcase
        return hit;
    endfunction

endpackage

// [spi_flash_protect_checker_assertions.sv]
// Purpose: assertions on the serial output pins of the flash block
// Assumes: raw pins seen on core_clk, sclk half period of four cycles
// Notes:   bound to the design from the bench top
module spi_flash_protect_checker
(
    input wire logic core_clk,   // core clock
    input wire logic resetn,     // async reset, active low
    input wire logic clkEn,      // clock enable
    input wire logic selN,       // chip select, active low
    input wire logic sclk,       // serial clock pin
    input wire logic dataIn,     // serial data in
    input wire logic writeProtN, // write protect, active low
    input wire logic dataOut,    // serial data out
    input wire logic dataOutEn   // output driven
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////
    a_idle_quiet: assert property (selN [*6] |-> !dataOutEn && !dataOut)
        else $error("output active while deselected");
    a_release_drop: assert property ($rose(selN) |-> ##[1:6] !dataOutEn)
        else $error("output not released after deselect");
    a_opcode_first: assert property ($fell(selN) |-> !dataOutEn [*8])
        else $error("output driven before opcode");
    a_enable_in_frame: assert property ($rose(dataOutEn) |-> !$past(selN, 4))
        else $error("output enabled outside a frame");
    a_enable_on_fall: assert property (
        $rose(dataOutEn) |-> !$past(sclk, 3) || !$past(sclk, 4))
        else $error("output enabled away from a falling clock");
    a_shift_on_fall: assert property (
        dataOutEn && $past(dataOutEn) && $changed(dataOut)
        |-> !$past(sclk, 3) || !$past(sclk, 4))
        else $error("output bit changed away from a falling clock");
    a_hold_while_high: assert property ((sclk && !selN) [*3] |-> $stable(dataOut))
        else $error("output bit changed while clock high");
    a_reset_quiet: assert property ($rose(resetn) |-> !dataOutEn [*3])
        else $error("output driven right after reset");
    c_read_start: cover property ($rose(dataOutEn));
    c_read_end: cover property ($fell(dataOutEn));
    c_bit_shift: cover property (dataOutEn && $changed(dataOut));
endmodule

// [spi_flash_write_protect_status.sv]
// Purpose: write-enable latch, status register and protection of a serial flash
// Assumes: link pins are asynchronous and sampled by core_clk
// Notes:   array contents are not modelled, only the busy time of array cycles

//////////////////////////////////////////////////////////////////////////////////
module spi_flash_write_protect_status
    import spi_flash_pkg::*;
#(
    parameter logic [7:0] MFR_CODE      = 8'hA5, // arbitrary value
    parameter logic [7:0] MEM_TYPE_CODE = 8'h3C, // arbitrary value
    parameter logic [7:0] MEM_CAP_CODE  = 8'h07, // arbitrary value
    parameter int STATUS_WRITE_CNT = STATUS_WRITE_CYCLES,
    parameter int PAGE_PROGRAM_CNT = PAGE_PROGRAM_CYCLES,
    parameter int SECTOR_ERASE_CNT = SECTOR_ERASE_CYCLES,
    parameter int BULK_ERASE_CNT   = BULK_ERASE_CYCLES
)(
    input  wire logic core_clk,   // core clock, 40 MHz
    input  wire logic resetn,     // async reset, active low
    input  wire logic clkEn,      // freezes all state while low
    input  wire logic selN,       // chip select pin, active low
    input  wire logic sclk,       // serial clock pin
    input  wire logic dataIn,     // serial data into device
    input  wire logic writeProtN, // write-protect pin, active low
    output logic      dataOut,    // serial data out of device
    output logic      dataOutEn   // serial output driven
);

    //////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and filter
    pins_type s1_r, s2_r, s3_r, filt_r, filtNxt;
    logic     sclkRise, sclkFall, selRise, selected;

    always_comb
    begin
        filtNxt  = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
        sclkRise = filtNxt.sclk & ~filt_r.sclk;
        sclkFall = ~filtNxt.sclk & filt_r.sclk;
        selRise  = filtNxt.selN & ~filt_r.selN;
        selected = ~filtNxt.selN;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_r   <= '{selN: 1'b1, sclk: 1'b0, dataIn: 1'b0, writeProtN: 1'b1};
            s2_r   <= '{selN: 1'b1, sclk: 1'b0, dataIn: 1'b0, writeProtN: 1'b1};
            s3_r   <= '{selN: 1'b1, sclk: 1'b0, dataIn: 1'b0, writeProtN: 1'b1};
            filt_r <= '{selN: 1'b1, sclk: 1'b0, dataIn: 1'b0, writeProtN: 1'b1};
        end
        else if (clkEn)
        begin
            s1_r   <= '{selN: selN, sclk: sclk, dataIn: dataIn, writeProtN: writeProtN};
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= filtNxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // control state declarations
    logic       latch_r, latch_nxt;
    logic [7:0] nv_r, nv_nxt;
    logic [7:0] pend_r, pend_nxt;
    cyc_type    cyc_r, cyc_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic       busy, hwProt;
    logic [7:0] statusView;

    always_comb
    begin
        busy   = (cyc_r != CYC_IDLE);
        hwProt = nv_r[BIT_SWD] & ~filtNxt.writeProtN;
        statusView = 8'h00;
        statusView[BIT_SWD]     = nv_r[BIT_SWD];
        statusView[BIT_PROT_HI] = nv_r[BIT_PROT_HI];
        statusView[BIT_PROT_LO] = nv_r[BIT_PROT_LO];
        statusView[BIT_LATCH]   = latch_r;
        statusView[BIT_BUSY]    = busy;
    end

    //////////////////////////////////////////////////////////////////////////////
    // serial link state
    logic [2:0]  bitIdx_r, bitIdx_nxt;
    logic [2:0]  byteCnt_r, byteCnt_nxt;
    logic [15:0] shift_r, shift_nxt;
    cmd_type     cmd_r, cmd_nxt;
    logic [1:0]  sector_r, sector_nxt;
    logic [7:0]  wrData_r, wrData_nxt;
    logic        dataOut_r, dataOut_nxt;
    logic        outEn_r, outEn_nxt;
    logic [7:0]  inByte;
    logic [4:0]  idIdx;
    logic [ID_BITS-1:0] idWord;

    always_comb
    begin
        bitIdx_nxt  = bitIdx_r;
        byteCnt_nxt = byteCnt_r;
        shift_nxt   = shift_r;
        cmd_nxt     = cmd_r;
        sector_nxt  = sector_r;
        wrData_nxt  = wrData_r;
        dataOut_nxt = dataOut_r;
        outEn_nxt   = outEn_r;
        inByte = {shift_r[6:0], filtNxt.dataIn};
        idWord = {MFR_CODE, MEM_TYPE_CODE, MEM_CAP_CODE};
        idIdx  = {byteCnt_r[1:0] - 2'h1, bitIdx_r};
        if (!selected)
        begin
            bitIdx_nxt  = '0;
            byteCnt_nxt = '0;
            cmd_nxt     = CMD_NONE;
            outEn_nxt   = 1'b0;
            dataOut_nxt = 1'b0;
        end
        else if (sclkRise)
        begin
            shift_nxt  = {shift_r[14:0], filtNxt.dataIn};
            bitIdx_nxt = bitIdx_r + 3'h1;
            if (bitIdx_r == BIT_LAST)
            begin
                if (byteCnt_r != BYTES_MAX)
                    byteCnt_nxt = byteCnt_r + 3'h1;
                if (byteCnt_r == '0)
                begin
                    unique case (inByte)
                        OP_LATCH_SET:    cmd_nxt = busy ? CMD_NONE : CMD_LATCH_SET;
                        OP_LATCH_CLEAR:  cmd_nxt = busy ? CMD_NONE : CMD_LATCH_CLEAR;
                        OP_IDENT_READ:   cmd_nxt = busy ? CMD_NONE : CMD_IDENT_READ;
                        OP_STATUS_READ:  cmd_nxt = CMD_STATUS_READ;
                        OP_STATUS_WRITE: cmd_nxt = busy ? CMD_NONE : CMD_STATUS_WRITE;
                        OP_PAGE_PROGRAM: cmd_nxt = busy ? CMD_NONE : CMD_PROGRAM;
                        OP_SECTOR_ERASE: cmd_nxt = busy ? CMD_NONE : CMD_SECTOR;
                        OP_BULK_ERASE:   cmd_nxt = busy ? CMD_NONE : CMD_BULK;
                        default:         cmd_nxt = CMD_NONE;
                    endcase
                end
                if (byteCnt_r == BYTES_SHORT)
                    wrData_nxt = inByte;
                if (byteCnt_r == BYTE_ADDR_MID)
                    sector_nxt = shift_nxt[8:7];
            end
        end
        else if (sclkFall && byteCnt_r != '0)
        begin
            if (cmd_r == CMD_STATUS_READ)
            begin
                outEn_nxt   = 1'b1;
                dataOut_nxt = statusView[BIT_LAST - bitIdx_r];
            end
            else if (cmd_r == CMD_IDENT_READ)
            begin
                outEn_nxt   = 1'b1;
                dataOut_nxt = (byteCnt_r <= ID_BYTES) ?
                              idWord[5'(ID_BITS - 1) - idIdx] : 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bitIdx_r  <= '0;
            byteCnt_r <= '0;
            shift_r   <= '0;
            cmd_r     <= CMD_NONE;
            sector_r  <= '0;
            wrData_r  <= '0;
            dataOut_r <= 1'b0;
            outEn_r   <= 1'b0;
        end
        else if (clkEn)
        begin
            bitIdx_r  <= bitIdx_nxt;
            byteCnt_r <= byteCnt_nxt;
            shift_r   <= shift_nxt;
            cmd_r     <= cmd_nxt;
            sector_r  <= sector_nxt;
            wrData_r  <= wrData_nxt;
            dataOut_r <= dataOut_nxt;
            outEn_r   <= outEn_nxt;
        end
    end

    assign dataOut   = dataOut_r;
    assign dataOutEn = outEn_r;

    //////////////////////////////////////////////////////////////////////////////
    // instruction execution on deselect and self-timed cycles
    logic onByte, arrayProt;

    always_comb
    begin
        latch_nxt = latch_r;
        nv_nxt   = nv_r;
        pend_nxt = pend_r;
        cyc_nxt  = cyc_r;
        cnt_nxt  = cnt_r;
        onByte    = (bitIdx_r == '0);
        arrayProt = isProtected({nv_r[BIT_PROT_HI], nv_r[BIT_PROT_LO]}, sector_r);
        if (busy)
        begin
            if (cnt_r <= 32'h0000_0001)
            begin
                if (cyc_r == CYC_STATUS)
                    nv_nxt = (nv_r & ~STATUS_WRITE_MASK) | (pend_r & STATUS_WRITE_MASK);
                cyc_nxt = CYC_IDLE;
                cnt_nxt = '0;
            end
            else
                cnt_nxt = cnt_r - 32'h0000_0001;
        end
        else if (selRise && onByte)
        begin
            unique case (cmd_r)
                CMD_LATCH_SET:
                    if (byteCnt_r == BYTES_SHORT)
                        latch_nxt = 1'b1;
                CMD_LATCH_CLEAR:
                    if (byteCnt_r == BYTES_SHORT)
                        latch_nxt = 1'b0;
                CMD_STATUS_WRITE:
                    if (byteCnt_r == BYTES_STATUS_WRITE && latch_r && !hwProt)
                    begin
                        pend_nxt  = wrData_r;
                        latch_nxt = 1'b0;
                        cyc_nxt  = CYC_STATUS;
                        cnt_nxt  = 32'(STATUS_WRITE_CNT);
                    end
                CMD_PROGRAM:
                    if (byteCnt_r >= BYTES_PROGRAM_MIN && latch_r && !arrayProt)
                    begin
                        latch_nxt = 1'b0;
                        cyc_nxt = CYC_ARRAY;
                        cnt_nxt = 32'(PAGE_PROGRAM_CNT);
                    end
                CMD_SECTOR:
                    if (byteCnt_r == BYTES_SECTOR_ERASE && latch_r && !arrayProt)
                    begin
                        latch_nxt = 1'b0;
                        cyc_nxt = CYC_ARRAY;
                        cnt_nxt = 32'(SECTOR_ERASE_CNT);
                    end
                CMD_BULK:
                    if (byteCnt_r == BYTES_SHORT && latch_r &&
                        !nv_r[BIT_PROT_HI] && !nv_r[BIT_PROT_LO])
                    begin
                        latch_nxt = 1'b0;
                        cyc_nxt = CYC_ARRAY;
                        cnt_nxt = 32'(BULK_ERASE_CNT);
                    end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            latch_r <= 1'b0;
            nv_r   <= NV_RESET;
            pend_r <= '0;
            cyc_r  <= CYC_IDLE;
            cnt_r  <= '0;
        end
        else if (clkEn)
        begin
            latch_r <= latch_nxt;
            nv_r   <= nv_nxt;
            pend_r <= pend_nxt;
            cyc_r  <= cyc_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

endmodule

// [spi_host_model.sv]
// Purpose: host controller driving select, clock and data in
// Assumes: mode 0 framing, 200 ns serial clock, msb first
// Notes:   the bench calls frame once per selection
module spi_host_model
(
    output logic      selN,      // chip select, active low
    output logic      sclk,      // serial clock, low outside frames
    output logic      dataIn,    // data toward device
    input  wire logic dataOut,   // data from device
    input  wire logic dataOutEn  // device output driven
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sawEn; // device drove data in last frame
    ////////////////////////////////////////////////////////////
    initial
    begin
        selN   = 1'b1;
        sclk   = 1'b0;
        dataIn = 1'b0;
        sawEn  = 1'b0;
    end
    task automatic frame(input logic [39:0] tx, input int nTx, input int nRx,
                         output logic [23:0] rx);
        int i;
        rx    = '0;
        sawEn = 1'b0;
        selN  = 1'b0;
        for (i = 0; i < nTx + nRx; i++)
        begin
            dataIn = (i < nTx) ? tx[39 - i] : ~dataIn;
            #100 sclk = 1'b1;
            // read bit sampled late in the high phase
            // undriven line reads as the inverse
            #100 rx = {rx[22:0], dataOutEn ? dataOut : ~dataOut};
            sawEn = sawEn | dataOutEn;
            sclk = 1'b0;
        end
        #100 selN = 1'b1;
        dataIn = ~dataIn;
        #300;
    endtask
endmodule

// [test_spi_flash_write_protect_status.sv]
// Purpose: self-checking bench for the flash protection block
// Assumes: 40 MHz core clock, host model owns the link pins
// Notes:   array cycles shortened, status write at default length
bind spi_flash_write_protect_status spi_flash_protect_checker u_chk (
    .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .selN(selN),
    .sclk(sclk), .dataIn(dataIn), .writeProtN(writeProtN),
    .dataOut(dataOut), .dataOutEn(dataOutEn));
`define CHK(nm, ex, got) \
    begin \
        totalChecks++; \
        if ((got) !== (ex)) \
        begin \
            failures++; \
            $display("[FAIL] %s exp %h got %h", nm, ex, got); \
        end \
    end
module test_spi_flash_write_protect_status
    import spi_flash_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] ID_MAKER = 8'h5A; // arbitrary value
    localparam logic [7:0] ID_TYPE  = 8'hC3; // arbitrary value
    localparam logic [7:0] ID_CAP   = 8'h70; // arbitrary value
    logic        core_clk, resetn, clkEn, writeProtN;
    logic        selN, sclk, dataIn, dataOut, dataOutEn;
    logic [23:0] rx;
    logic [7:0]  st;
    int          failures, totalChecks;
    ////////////////////////////////////////////////////////////
    spi_flash_write_protect_status #(
        .MFR_CODE(ID_MAKER), .MEM_TYPE_CODE(ID_TYPE), .MEM_CAP_CODE(ID_CAP),
        .PAGE_PROGRAM_CNT(200), .SECTOR_ERASE_CNT(400), .BULK_ERASE_CNT(2000)
    ) u_dut (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .selN(selN),
        .sclk(sclk), .dataIn(dataIn), .writeProtN(writeProtN),
        .dataOut(dataOut), .dataOutEn(dataOutEn));
    spi_host_model u_host (.selN(selN), .sclk(sclk), .dataIn(dataIn),
        .dataOut(dataOut), .dataOutEn(dataOutEn));
    always #12.5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic op(input logic [7:0] c, input int n);
        u_host.frame({c, 32'h0000_0000}, n, 0, rx);
    endtask
    task automatic wr(input logic [7:0] d, input int n);
        u_host.frame({OP_STATUS_WRITE, d, 24'h00_0000}, n, 0, rx);
    endtask
    task automatic eraseSec(input logic [23:0] a);
        op(OP_LATCH_SET, 8);
        u_host.frame({OP_SECTOR_ERASE, a, 8'h00}, 32, 0, rx);
    endtask
    task automatic chkStatus(input string nm, input logic [7:0] ex);
        u_host.frame({OP_STATUS_READ, 32'h0000_0000}, 8, 8, rx);
        st = rx[7:0];
        `CHK(nm, ex, st)
    endtask
    task automatic setPin(input logic v);
        @(negedge core_clk);
        writeProtN = v;
    endtask
    task automatic waitIdle();
        int n;
        for (n = 0; n < 60; n++)
        begin
            u_host.frame({OP_STATUS_READ, 32'h0000_0000}, 8, 8, rx);
            if (rx[BIT_BUSY] === 1'b0)
                return;
        end
        failures++;
        end_sim();
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_latch();
        chkStatus("after reset", 8'h00);
        op(OP_LATCH_SET, 8);
        chkStatus("latch set", 8'h02);
        op(OP_LATCH_CLEAR, 8);
        chkStatus("latch cleared", 8'h00);
        op(OP_LATCH_SET, 9);
        chkStatus("set off boundary", 8'h00);
        wr(8'h8C, 16);
        chkStatus("write without latch", 8'h00);
        // frozen clock enable: instruction never seen
        @(negedge core_clk);
        clkEn = 1'b0;
        op(OP_LATCH_SET, 8);
        clkEn = 1'b1;
        chkStatus("frozen latch set", 8'h00);
    endtask
    task automatic t_swrite();
        op(OP_LATCH_SET, 8);
        wr(8'h80, 15);
        chkStatus("write off boundary", 8'h02);
        wr(8'hFF, 16);
        u_host.frame({OP_STATUS_READ, 32'h0000_0000}, 8, 16, rx);
        `CHK("busy read twice", 16'h0101, rx[15:0])
        waitIdle();
        chkStatus("written bits", 8'h8C);
    endtask
    task automatic t_protect();
        op(OP_LATCH_SET, 8);
        op(OP_BULK_ERASE, 8);
        chkStatus("bulk erase protected", 8'h8E);
        u_host.frame({OP_SECTOR_ERASE, 32'h0000_0000}, 32, 0, rx);
        chkStatus("erase all protected", 8'h8E);
        setPin(1'b0);
        wr(8'h04, 16);
        chkStatus("write under hw protect", 8'h8E);
        setPin(1'b1);
        wr(8'h84, 16);
        waitIdle();
        chkStatus("write with pin high", 8'h84);
        setPin(1'b0);
        eraseSec(24'h01_8000);
        chkStatus("protected sector", 8'h86);
        eraseSec(24'h00_0000);
        chkStatus("open sector busy", 8'h85);
        waitIdle();
        chkStatus("erase done", 8'h84);
    endtask
    task automatic t_order();
        setPin(1'b1);
        op(OP_LATCH_SET, 8);
        wr(8'h00, 16);
        waitIdle();
        setPin(1'b0);
        op(OP_LATCH_SET, 8);
        wr(8'h80, 16);
        waitIdle();
        chkStatus("disable set pin low", 8'h80);
        op(OP_LATCH_SET, 8);
        wr(8'h00, 16);
        chkStatus("protection entered", 8'h82);
        setPin(1'b1);
        wr(8'h00, 16);
        waitIdle();
        chkStatus("protection left", 8'h00);
    endtask
    task automatic t_ident();
        u_host.frame({OP_IDENT_READ, 32'h0000_0000}, 8, 24, rx);
        `CHK("ident bytes", {ID_MAKER, ID_TYPE, ID_CAP}, rx)
        u_host.frame({OP_IDENT_READ, 32'h0000_0000}, 8, 5, rx);
        chkStatus("after aborted ident", 8'h00);
        op(OP_LATCH_SET, 8);
        op(OP_BULK_ERASE, 8);
        u_host.frame({OP_IDENT_READ, 32'h0000_0000}, 8, 24, rx);
        `CHK("ident while busy", 1'b0, u_host.sawEn)
        chkStatus("erase undisturbed", 8'h01);
        waitIdle();
        chkStatus("bulk erase done", 8'h00);
    endtask
    task automatic t_program();
        op(OP_LATCH_SET, 8);
        u_host.frame({OP_PAGE_PROGRAM, 32'h0000_00A5}, 40, 0, rx);
        chkStatus("program busy", 8'h01);
        waitIdle();
        chkStatus("program done", 8'h00);
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        core_clk    = 1'b0;
        resetn      = 1'b0;
        clkEn       = 1'b1;
        writeProtN  = 1'b1;
        failures    = 0;
        totalChecks = 0;
        repeat (2) @(negedge core_clk);
        resetn = 1'b1;
        t_latch();
        t_swrite();
        t_protect();
        t_order();
        t_ident();
        t_program();
        end_sim();
    end
endmodule
